// ---- fan_pwm_drive.sv ----
module fan_pwm_drive #(
   parameter int CNT_W = 16,
   parameter int unsigned DIV_SLOW0 = int'(fan_pwm_pkg::DIV_SLOW0),
   parameter int unsigned DIV_SLOW1 = int'(fan_pwm_pkg::DIV_SLOW1)
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic fan_drive,
   output logic fan_drive_oe,
   output logic [1:0] tach_div_sel,
   output logic [3:0] tach_divisor
);
   fan_pwm_pkg::pwm_ctrl_t pwm;
   fan_pwm_pkg::clk_cfg_t cfg;
   logic [CNT_W-1:0] period;
   logic [5:0] slot;
   logic tick;

   // Cycles per slot for the chosen source, select and doubler
   function automatic logic [CNT_W-1:0] slot_period(input logic src, input logic sel,
                                                    input logic dbl);
      logic [CNT_W-1:0] base;
      case ({src, sel})
         2'b00: base = CNT_W'(fan_pwm_pkg::DIV_FAST0);
         2'b01: base = CNT_W'(fan_pwm_pkg::DIV_FAST1);
         2'b10: base = CNT_W'(DIV_SLOW0);
         default: base = CNT_W'(DIV_SLOW1);
      endcase
      slot_period = dbl ? (base >> 1) : base;
   endfunction : slot_period

   // Host writes to the two runtime registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         pwm <= fan_pwm_pkg::PWM_RST;
         cfg <= fan_pwm_pkg::CFG_RST;
      end else if (reg_wr) begin
         if (reg_addr == fan_pwm_pkg::OFF_PWM) begin
            pwm <= reg_wdata;
         end
         if (reg_addr == fan_pwm_pkg::OFF_CFG) begin
            cfg <= reg_wdata & fan_pwm_pkg::CFG_MASK;
         end
      end
   end

   // Registered read data; unmapped offsets read zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= fan_pwm_pkg::READ_NONE;
      end else if (reg_rd) begin
         case (reg_addr)
            fan_pwm_pkg::OFF_PWM: reg_rdata <= pwm;
            fan_pwm_pkg::OFF_CFG: reg_rdata <= cfg;
            default: reg_rdata <= fan_pwm_pkg::READ_NONE;
         endcase
      end
   end

   // Slot rate selection
   always_comb begin
      period = slot_period(cfg.source, pwm.clk_sel, cfg.doubler);
   end

   slot_tick #(
      .W(CNT_W)
   ) u_tick (
      .mclk(mclk),
      .reset(reset),
      .period(period),
      .tick(tick)
   );

   // Free-running slot counter
   always_ff @(posedge mclk) begin
      if (reset) begin
         slot <= '0;
      end else if (tick) begin
         slot <= slot + 1'b1;
      end
   end

   // Drive pin: force high, else compare slot against duty level
   always_ff @(posedge mclk) begin
      if (reset) begin
         fan_drive <= 1'b0;
         fan_drive_oe <= 1'b1;
      end else begin
         fan_drive_oe <= 1'b1;
         if (pwm.force_high) begin
            fan_drive <= 1'b1;
         end else begin
            fan_drive <= (slot < pwm.duty_level);
         end
      end
   end

   // Divisor choice handed to the speed monitor
   always_ff @(posedge mclk) begin
      if (reset) begin
         tach_div_sel <= fan_pwm_pkg::TDIV_BY2;
         tach_divisor <= 4'h1 << fan_pwm_pkg::TDIV_BY2;
      end else begin
         tach_div_sel <= cfg.tach_div;
         tach_divisor <= 4'h1 << cfg.tach_div;
      end
   end

   // Helper: cycles between slot ticks while the rate holds still
   logic [CNT_W:0] gap;
   logic [CNT_W-1:0] period_q;
   logic primed;
   always_ff @(posedge mclk) begin
      if (reset) begin
         gap <= '0;
         period_q <= '0;
         primed <= 1'b0;
      end else begin
         period_q <= period;
         gap <= tick ? (CNT_W+1)'(1) : gap + 1'b1;
         if (period != period_q) begin
            primed <= 1'b0;
         end else if (tick) begin
            primed <= 1'b1;
         end
      end
   end

   property p_reset_low;
      @(posedge mclk) reset |=> (!fan_drive && fan_drive_oe);
   endproperty
   a_reset_low: assert property (p_reset_low) else $error("drive not low after reset");

   property p_force_high;
      @(posedge mclk) disable iff (reset) pwm.force_high |=> fan_drive;
   endproperty
   a_force_high: assert property (p_force_high) else $error("force bit ignored");

   property p_zero_low;
      @(posedge mclk) disable iff (reset)
         (!pwm.force_high && pwm.duty_level == fan_pwm_pkg::DUTY_MIN) |=> !fan_drive;
   endproperty
   a_zero_low: assert property (p_zero_low) else $error("pulse at zero duty");

   sequence s_max_last_slot;
      !pwm.force_high && pwm.duty_level == fan_pwm_pkg::DUTY_MAX && slot == 6'h3f;
   endsequence
   sequence s_max_first_slot;
      !pwm.force_high && pwm.duty_level == fan_pwm_pkg::DUTY_MAX && slot == 6'h00;
   endsequence
   property p_max_duty;
      @(posedge mclk) disable iff (reset)
         (s_max_last_slot |=> !fan_drive) and (s_max_first_slot |=> fan_drive);
   endproperty
   a_max_duty: assert property (p_max_duty) else $error("max duty wrong");

   property p_duty_compare;
      @(posedge mclk) disable iff (reset)
         !pwm.force_high |=> fan_drive == ($past(slot) < $past(pwm.duty_level));
   endproperty
   a_duty_compare: assert property (p_duty_compare) else $error("duty compare wrong");

   property p_fast_rate;
      @(posedge mclk) disable iff (reset)
         (!cfg.source && !pwm.clk_sel && !cfg.doubler) |->
            period == CNT_W'(fan_pwm_pkg::DIV_FAST0);
   endproperty
   a_fast_rate: assert property (p_fast_rate) else $error("base rate wrong");

   property p_doubler;
      @(posedge mclk) disable iff (reset)
         cfg.doubler |-> period == (cfg.source ?
            (pwm.clk_sel ? CNT_W'(DIV_SLOW1 / 2) : CNT_W'(DIV_SLOW0 / 2)) :
            (pwm.clk_sel ? CNT_W'(fan_pwm_pkg::DIV_FAST1 / 2) :
               CNT_W'(fan_pwm_pkg::DIV_FAST0 / 2)));
   endproperty
   a_doubler: assert property (p_doubler) else $error("doubler not halving");

   property p_tick_gap;
      @(posedge mclk) disable iff (reset)
         (tick && primed && period == period_q) |-> gap == {1'b0, period};
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("slot spacing wrong");

   property p_slot_advance;
      @(posedge mclk) disable iff (reset) tick |=> slot == $past(slot) + 6'h01;
   endproperty
   a_slot_advance: assert property (p_slot_advance) else $error("slot not advancing");

   property p_read_back;
      @(posedge mclk) disable iff (reset)
         (reg_rd && reg_addr == fan_pwm_pkg::OFF_PWM) |=> reg_rdata == $past(pwm);
   endproperty
   a_read_back: assert property (p_read_back) else $error("readback wrong");

   property p_div_out;
      @(posedge mclk) disable iff (reset)
         ##1 (tach_div_sel == $past(cfg.tach_div) && tach_divisor == (4'h1 << tach_div_sel));
   endproperty
   a_div_out: assert property (p_div_out) else $error("divisor output wrong");

   property p_div_reset;
      @(posedge mclk) reset |=> (tach_div_sel == fan_pwm_pkg::TDIV_BY2 && tach_divisor == 4'h2);
   endproperty
   a_div_reset: assert property (p_div_reset) else $error("divisor reset wrong");
endmodule : fan_pwm_drive

// ---- fan_pwm_pkg.sv ----
package fan_pwm_pkg;

   // Core clock and output shaping
   localparam longint unsigned CLK_HZ = 64'd125_000_000;
   localparam longint unsigned SLOTS = 64'd64;
   localparam longint unsigned MILLI = 64'd1000;

   // Base output frequencies in millihertz (doubler clear)
   localparam longint unsigned F_FAST0_MHZ = 64'd15_625_000;
   localparam longint unsigned F_FAST1_MHZ = 64'd23_438_000;
   localparam longint unsigned F_SLOW0_MHZ = 64'd40_000;
   localparam longint unsigned F_SLOW1_MHZ = 64'd60_000;

   // Clock cycles per slot, rounded down
   localparam longint unsigned DIV_FAST0 = (CLK_HZ * MILLI) / (SLOTS * F_FAST0_MHZ);
   localparam longint unsigned DIV_FAST1 = (CLK_HZ * MILLI) / (SLOTS * F_FAST1_MHZ);
   localparam longint unsigned DIV_SLOW0 = (CLK_HZ * MILLI) / (SLOTS * F_SLOW0_MHZ);
   localparam longint unsigned DIV_SLOW1 = (CLK_HZ * MILLI) / (SLOTS * F_SLOW1_MHZ);

   // Register offsets
   localparam logic [7:0] OFF_PWM = 8'h56;
   localparam logic [7:0] OFF_CFG = 8'h58;

   // Reset values and writable bits
   localparam logic [7:0] PWM_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h10;
   localparam logic [7:0] CFG_MASK = 8'h35;
   localparam logic [7:0] READ_NONE = 8'h00;

   // Duty endpoints and reset tach divisor code
   localparam logic [5:0] DUTY_MIN = 6'h00;
   localparam logic [5:0] DUTY_MAX = 6'h3f;
   localparam logic [1:0] TDIV_BY2 = 2'h1;

   // Waveform control byte
   typedef struct packed {
      logic clk_sel;
      logic [5:0] duty_level;
      logic force_high;
   } pwm_ctrl_t;

   // Clock configuration byte
   typedef struct packed {
      logic [1:0] rsv_hi;
      logic [1:0] tach_div;
      logic rsv3;
      logic doubler;
      logic rsv1;
      logic source;
   } clk_cfg_t;

endpackage : fan_pwm_pkg

// ---- slot_tick.sv ----
// Free-running divider: one-cycle pulse every period cycles
module slot_tick #(
   parameter int W = 16
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [W-1:0] period,
   output logic tick
);
   logic [W-1:0] cnt;

   // Count up to period-1, then wrap and pulse
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt >= period - 1'b1) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : slot_tick

// ---- fan_motor_model.sv ----
// Fan motor input: measures high time and period of the drive waveform
module fan_motor_model (
   input wire logic mclk,
   input wire logic fan_drive,
   input wire logic fan_drive_oe,
   output logic [31:0] high_cnt,
   output logic [31:0] period_cnt,
   output int edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev = 1'b0;
   logic lvl;
   logic [31:0] run = 32'h0;
   logic [31:0] hi = 32'h0;
   logic [31:0] hi_last = 32'h0;
   logic [31:0] run_last = 32'h0;
   int seen = 0;
   // An undriven pin is read low through the input bias
   assign lvl = fan_drive_oe & fan_drive;
   // Reported counts come from one process each
   assign high_cnt = hi_last;
   assign period_cnt = run_last;
   assign edges = seen;
   // Each rising edge closes one period and reports its counts
   always @(posedge mclk) begin
      if (lvl && !prev) begin
         run_last <= run;
         hi_last <= hi;
         run <= 32'h1;
         hi <= 32'h1;
         seen <= seen + 1;
      end else begin
         run <= run + 32'h1;
         hi <= hi + {31'h0, lvl};
      end
      prev <= lvl;
   end
endmodule : fan_motor_model

// ---- testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int S0 = 20;
   localparam int S1 = 14;
   logic mclk, reset, reg_wr, reg_rd, fan_drive, fan_drive_oe;
   logic rd_seen = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, seed;
   logic [1:0] tach_div_sel;
   logic [3:0] tach_divisor;
   logic [31:0] high_cnt, period_cnt;
   logic [5:0] d;
   logic [7:0] q[$];
   int edges, e0, m, p, i;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int order[8] = '{7, 6, 3, 2, 5, 4, 1, 0};
   fan_pwm_pkg::pwm_ctrl_t pc;
   fan_pwm_pkg::clk_cfg_t cc;
   fan_pwm_drive #(.DIV_SLOW0(S0), .DIV_SLOW1(S1)) uut (.mclk(mclk), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fan_drive(fan_drive), .fan_drive_oe(fan_drive_oe),
      .tach_div_sel(tach_div_sel), .tach_divisor(tach_divisor));
   fan_motor_model fan (.mclk(mclk), .fan_drive(fan_drive), .fan_drive_oe(fan_drive_oe),
      .high_cnt(high_cnt), .period_cnt(period_cnt), .edges(edges));
   // Clock at 125 MHz
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk) #1;
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge mclk) #1;
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk) #1;
      reg_addr = a;
      q.push_back(exp);
      reg_rd = 1'b1;
      @(posedge mclk) #1;
      reg_rd = 1'b0;
   endtask : rd
   task automatic rst3;
      @(posedge mclk) #1;
      reset = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      reset = 1'b0;
   endtask : rst3
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   // Read data is compared with the oldest note one cycle after the strobe
   always @(posedge mclk) begin
      if (rd_seen && q.size() > 0) begin
         check(reg_rdata, q.pop_front(), "read data");
      end
      rd_seen <= reg_rd;
   end
   // Hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 16'h0};
      seed = 8'h38;
      rst3();
      // Doubled slow source 0 rate (10 cycles per slot) first so each 600-cycle endpoint check spans 60 slots
      cc = '0;
      cc.doubler = 1'b1;
      cc.source = 1'b1;
      wr(fan_pwm_pkg::OFF_CFG, cc);
      e0 = edges;
      for (i = 0; i < 600; i++) begin
         @(posedge mclk) #1;
         check(fan_drive, 32'h0, "zero duty");
      end
      check(edges, e0, "zero duty pulses");
      pc = '0;
      pc.duty_level = 6'h05;
      pc.force_high = 1'b1;
      wr(fan_pwm_pkg::OFF_PWM, pc);
      for (i = 0; i < 600; i++) begin
         @(posedge mclk) #1;
         check(fan_drive, 32'h1, "force high");
      end
      $display("endpoint test done");
      for (m = 0; m < 8; m++) begin
         p = order[m][1] ? (order[m][0] ? S1 : S0) : (order[m][0] ?
            int'(fan_pwm_pkg::DIV_FAST1) : int'(fan_pwm_pkg::DIV_FAST0));
         p = p >> order[m][2];
         seed = lfsr(seed);
         d = (seed[5:0] == 6'h00) ? 6'h01 : seed[5:0];
         d = (order[m] == 0) ? fan_pwm_pkg::DUTY_MAX : d;
         cc = '0;
         cc.tach_div = fan_pwm_pkg::TDIV_BY2;
         cc.doubler = order[m][2];
         cc.source = order[m][1];
         pc = '0;
         pc.clk_sel = order[m][0];
         pc.duty_level = d;
         wr(fan_pwm_pkg::OFF_CFG, cc);
         wr(fan_pwm_pkg::OFF_PWM, pc);
         e0 = edges;
         for (i = 0; i < 40000 && edges < e0 + 3; i++) @(posedge mclk);
         #1;
         check(32'(edges >= e0 + 3), 32'h1, "edge count");
         check(period_cnt, 32'(64 * p), "period");
         check(high_cnt, 32'(int'(d) * p), "high time");
      end
      $display("rate test done");
      for (i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         cc = seed;
         cc.tach_div = i[1:0];
         wr(fan_pwm_pkg::OFF_CFG, cc);
         repeat (2) @(posedge mclk);
         #1;
         check(tach_div_sel, i[1:0], "divisor code");
         check(tach_divisor, 4'h1 << i, "divisor");
         rd(fan_pwm_pkg::OFF_CFG, cc & fan_pwm_pkg::CFG_MASK);
      end
      rd(8'h57, fan_pwm_pkg::READ_NONE);
      wr(8'h57, 8'hff);
      rd(fan_pwm_pkg::OFF_PWM, pc);
      $display("register test done");
      rst3();
      check(fan_drive, 32'h0, "reset drive");
      check(fan_drive_oe, 32'h1, "reset enable");
      check(tach_div_sel, fan_pwm_pkg::TDIV_BY2, "reset code");
      check(tach_divisor, 4'h2, "reset divisor");
      rd(fan_pwm_pkg::OFF_PWM, fan_pwm_pkg::PWM_RST);
      rd(fan_pwm_pkg::OFF_CFG, fan_pwm_pkg::CFG_RST);
      repeat (2) @(posedge mclk);
      #1;
      check(q.size(), 32'h0, "reads answered");
      $display("reset test done");
      test_done();
   end
endmodule : testbench
